// ===== verilog/mrd_top.sv
`timescale 1ns/1ps
module mrd_top (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [11:0]  reg_addr,
    input  wire logic         reg_wr,
    input  wire logic [15:0]  reg_wdata,
    output logic      [15:0]  reg_rdata,
    output logic      [31:0]  relay_drive,
    output logic      [11:0]  spdt_coil,
    output logic      [1:0]   sp6t_clear,
    output logic      [11:0]  sp6t_coil,
    input  wire logic [11:0]  spdt_position_readback,
    input  wire logic [11:0]  sp6t_position_readback
);
    // register state
    logic [15:0]                  relay_low;
    logic [15:0]                  relay_high;
    logic [15:0]                  next_relay_low;
    logic [15:0]                  next_relay_high;
    logic [15:0]                  delay;
    logic [15:0]                  next_delay;
    logic [1:0]                   fitted;
    logic [1:0]                   next_fitted;
    logic [15:0]                  next_rdata;
    // read-back synchroniser
    logic [23:0]                  rb_meta;
    logic [23:0]                  rb_sync;
    // per-switch command plumbing
    logic [mrd_pkg::CNT_W-1:0]    pulse_cycles;
    logic [7:0]                   start;
    logic [7:0]                   next_start;
    logic [2:0]                   tgt [8];
    logic [2:0]                   next_tgt [8];
    logic [7:0]                   busy;
    logic                         wr_spdt;
    logic                         wr_sp6t;

    // one command interface per switch: six two-way, then the two six-way slots
    mrd_seq_if sif [8] ();

    // write strobe qualified by one exact offset; a partial decode would alias
    function automatic logic wr_hit(input logic wr, input logic [11:0] addr, input logic [11:0] off);
        return wr && (addr == off);
    endfunction : wr_hit

    // a switch takes a command only with no pulse running and none pending
    function automatic logic idle_slot(input logic busy_now, input logic start_now);
        return !busy_now && !start_now;
    endfunction : idle_slot

    // relay words, delay and slot configuration writes
    // unmapped and read-only offsets fall through and are ignored
    always_comb begin
        next_relay_low  = relay_low;
        next_relay_high = relay_high;
        next_delay      = delay;
        next_fitted     = fitted;
        if (reg_wr) begin
            unique case (reg_addr)
                mrd_pkg::RELAY_LOW_OFF:  next_relay_low  = reg_wdata;
                mrd_pkg::RELAY_HIGH_OFF: next_relay_high = reg_wdata;
                mrd_pkg::DELAY_OFF:      next_delay      = reg_wdata;
                mrd_pkg::CONFIG_OFF:     next_fitted     = reg_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // relay drive loads from next values, so it moves on the write edge
    // reset releases every relay channel; latching switches are left alone
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            relay_low   <= mrd_pkg::RELAY_RESET;
            relay_high  <= mrd_pkg::RELAY_RESET;
            delay       <= mrd_pkg::DELAY_RESET;
            fitted      <= mrd_pkg::CONFIG_RESET;
            relay_drive <= {mrd_pkg::RELAY_RESET, mrd_pkg::RELAY_RESET};
        end else begin
            relay_low   <= next_relay_low;
            relay_high  <= next_relay_high;
            delay       <= next_delay;
            fitted      <= next_fitted;
            relay_drive <= {next_relay_high, next_relay_low}; // 32 channels
        end
    end

    // a zero delay would wrap the counter into the longest pulse, so it counts as one unit
    // delay counts microseconds; a full 16-bit delay still fits the counter
    // each sequencer copies the length at start, so a mid-pulse delay write
    // only affects the pulses that follow it
    assign pulse_cycles = (delay == 16'h0000) ? 22'(mrd_pkg::UNIT_CYCLES)
                          : 22'(delay) * 22'(mrd_pkg::UNIT_CYCLES);

    // command strobes, one per switch family
    assign wr_spdt = wr_hit(reg_wr, reg_addr, mrd_pkg::SPDT_CMD_OFF);
    assign wr_sp6t = wr_hit(reg_wr, reg_addr, mrd_pkg::SP6T_CMD_OFF);

    // per-switch command decode; a command to a busy switch is dropped
    // dropping rather than queueing keeps each coil owned by one sequencer,
    // so software polls the busy word before the next command to a switch
    for (genvar g = 0; g < mrd_pkg::SWITCH_COUNT; g++) begin : g_sw
        if (g < mrd_pkg::SPDT_COUNT) begin : g_dec2
            logic idx_hit;

            // index field picks the switch, one bit picks the throw
            assign idx_hit = (reg_wdata[mrd_pkg::SPDT_IDX_LSB +: 3] == 3'(g));

            // start strobe and target for this two-way switch
            always_comb begin
                next_start[g] = 1'b0;
                next_tgt[g]   = tgt[g];
                if (wr_spdt && idle_slot(busy[g], start[g]) && idx_hit) begin
                    next_start[g] = 1'b1;
                    next_tgt[g]   = {2'h0, reg_wdata[mrd_pkg::SPDT_POS_BIT]};
                end
            end
        end else begin : g_dec6
            logic slot_hit;
            logic chan_ok;

            // absent slots and channel indices of six or more are ignored
            assign slot_hit = fitted[g - mrd_pkg::SPDT_COUNT] &&
                              (reg_wdata[mrd_pkg::SP6T_SLOT_BIT] == 1'(g - mrd_pkg::SPDT_COUNT));
            assign chan_ok  = (reg_wdata[mrd_pkg::SP6T_CHAN_LSB +: 3] < 3'(mrd_pkg::POSITIONS));

            // start strobe and target for this six-way slot
            always_comb begin
                next_start[g] = 1'b0;
                next_tgt[g]   = tgt[g];
                if (wr_sp6t && idle_slot(busy[g], start[g]) && slot_hit && chan_ok) begin
                    next_start[g] = 1'b1;
                    next_tgt[g]   = reg_wdata[mrd_pkg::SP6T_CHAN_LSB +: 3];
                end
            end
        end

        // start is a one-cycle strobe; tgt keeps the last accepted position
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                start[g] <= 1'b0;
                tgt[g]   <= 3'h0;
            end else begin
                start[g] <= next_start[g];
                tgt[g]   <= next_tgt[g];
            end
        end

        // every sequencer sees one shared length; only six-way slots clear first
        assign sif[g].start        = start[g];
        assign sif[g].target       = tgt[g];
        assign sif[g].pulse_cycles = pulse_cycles;
        assign sif[g].clr_first    = (g >= mrd_pkg::SPDT_COUNT);
        assign busy[g]             = sif[g].busy;

        // one pulse sequencer per switch, so switches run side by side
        mrd_coil_seq u_seq (
            .ref_clk (ref_clk),
            .rst_b   (rst_b),
            .sif     (sif[g])
        );

        // fixed slot-to-pin mapping
        // pins follow switch position, there is no remapping table
        if (g < mrd_pkg::SPDT_COUNT) begin : g_spdt
            assign spdt_coil[2*g +: 2] = sif[g].coil[1:0];
        end else begin : g_sp6t
            assign sp6t_coil[mrd_pkg::POSITIONS*(g-mrd_pkg::SPDT_COUNT) +: mrd_pkg::POSITIONS] = sif[g].coil;
            assign sp6t_clear[g - mrd_pkg::SPDT_COUNT] = sif[g].clr_line;
        end
    end

    // spare-contact read-back from the pins, two flops before use
    // contacts are asynchronous to the clock; nothing but rb_sync reads rb_meta
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rb_meta <= 24'h000000;
            rb_sync <= 24'h000000;
        end else begin
            rb_meta <= {sp6t_position_readback, spdt_position_readback};
            rb_sync <= rb_meta;
        end
    end

    // read mux; status is live contact state, never a stored copy
    // unmapped offsets read zero; command words are write-only
    always_comb begin
        unique case (reg_addr)
            mrd_pkg::RELAY_LOW_OFF:  next_rdata = relay_low;
            mrd_pkg::RELAY_HIGH_OFF: next_rdata = relay_high;
            mrd_pkg::DELAY_OFF:      next_rdata = delay;
            mrd_pkg::CONFIG_OFF:     next_rdata = {14'h0000, fitted};
            mrd_pkg::BUSY_OFF:       next_rdata = {8'h00, busy};
            mrd_pkg::SPDT_RB_OFF:    next_rdata = {4'h0, rb_sync[11:0]};
            mrd_pkg::SP6T_RB_OFF:    next_rdata = {4'h0, rb_sync[23:12]};
            default:                 next_rdata = 16'h0000;
        endcase
    end

    // answer registered, one cycle after the address is sampled
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : mrd_top

// ===== verilog/mrd_pkg.sv
package mrd_pkg;
    // register offsets on the 16-bit register port
    localparam logic [11:0] RELAY_LOW_OFF    = 12'h400;
    localparam logic [11:0] RELAY_HIGH_OFF   = 12'h402;
    localparam logic [11:0] DELAY_OFF        = 12'h410;
    localparam logic [11:0] SPDT_CMD_OFF     = 12'h412;
    localparam logic [11:0] SP6T_CMD_OFF     = 12'h414;
    localparam logic [11:0] CONFIG_OFF       = 12'h416;
    localparam logic [11:0] BUSY_OFF         = 12'h418;
    localparam logic [11:0] SPDT_RB_OFF      = 12'h41a;
    localparam logic [11:0] SP6T_RB_OFF      = 12'h41c;

    // switch population and field layout
    localparam int          SPDT_COUNT       = 6;
    localparam int          SP6T_COUNT       = 2;
    localparam int          SWITCH_COUNT     = 8;
    localparam int          POSITIONS        = 6;
    localparam int          SPDT_IDX_LSB     = 0;
    localparam int          SPDT_POS_BIT     = 3;
    localparam int          SP6T_SLOT_BIT    = 0;
    localparam int          SP6T_CHAN_LSB    = 1;

    // reset values
    localparam logic [15:0] RELAY_RESET      = 16'h0000;
    localparam logic [15:0] DELAY_RESET      = 16'h000a;
    localparam logic [1:0]  CONFIG_RESET     = 2'h0;

    // coil pulse time base: delay register counts whole microseconds
    localparam int          DELAY_UNIT_NS    = 1000;
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          UNIT_CYCLES      = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam int          CNT_W            = 22;

    typedef enum logic [1:0] {MRD_IDLE, MRD_CLEAR, MRD_SET} mrd_state_t;

    // one coil line per position index, none for an out-of-range index
    function automatic logic [5:0] mrd_onehot(input logic [2:0] idx);
        logic [5:0] v;
        v = 6'h00;
        if (idx < 3'h6) begin
            v[idx] = 1'b1;
        end
        return v;
    endfunction : mrd_onehot
endpackage : mrd_pkg

// ===== verilog/mrd_seq_if.sv
`timescale 1ns/1ps
interface mrd_seq_if;
    logic                             start;
    logic                             clr_first;
    logic [2:0]                       target;
    logic [mrd_pkg::CNT_W-1:0]        pulse_cycles;
    logic                             busy;
    logic [5:0]                       coil;
    logic                             clr_line;

    modport ctrl (output start, output clr_first, output target, output pulse_cycles,
                  input busy, input coil, input clr_line);
    modport seq  (input start, input clr_first, input target, input pulse_cycles,
                  output busy, output coil, output clr_line);
endinterface : mrd_seq_if

// ===== verilog/mrd_coil_seq.sv
`timescale 1ns/1ps
module mrd_coil_seq (
    input  wire logic  ref_clk,
    input  wire logic  rst_b,
    mrd_seq_if.seq     sif
);
    mrd_pkg::mrd_state_t            state;
    mrd_pkg::mrd_state_t            next_state;
    logic [mrd_pkg::CNT_W-1:0]      cnt;
    logic [mrd_pkg::CNT_W-1:0]      next_cnt;
    logic [mrd_pkg::CNT_W-1:0]      len;
    logic [mrd_pkg::CNT_W-1:0]      next_len;
    logic [2:0]                     tgt;
    logic [2:0]                     next_tgt;
    logic [5:0]                     next_coil;
    logic                           next_clr;
    logic                           next_busy;

    // clear phase when clr_first is set, then set phase, each held for the programmed length
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_len   = len;
        next_tgt   = tgt;
        unique case (state)
            mrd_pkg::MRD_IDLE: begin
                // a repeat of the current channel is not filtered out
                if (sif.start) begin
                    next_tgt = sif.target;
                    next_len = sif.pulse_cycles;
                    next_cnt = sif.pulse_cycles;
                    next_state = sif.clr_first ? mrd_pkg::MRD_CLEAR : mrd_pkg::MRD_SET;
                end
            end
            mrd_pkg::MRD_CLEAR: begin
                if (cnt == 22'h000001) begin
                    next_cnt   = len;
                    next_state = mrd_pkg::MRD_SET;  // set only after clear ends
                end else begin
                    next_cnt = cnt - 22'h000001;
                end
            end
            mrd_pkg::MRD_SET: begin
                if (cnt == 22'h000001) begin
                    next_state = mrd_pkg::MRD_IDLE; // coil released after pulse
                end else begin
                    next_cnt = cnt - 22'h000001;
                end
            end
        endcase
        // outputs follow the next state so they line up with it exactly
        next_clr  = (next_state == mrd_pkg::MRD_CLEAR);
        next_coil = (next_state == mrd_pkg::MRD_SET) ? mrd_pkg::mrd_onehot(next_tgt) : 6'h00;
        next_busy = (next_state != mrd_pkg::MRD_IDLE);
    end

    // reset only idles the drives: no clear pulse on power loss
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= mrd_pkg::MRD_IDLE;
            cnt          <= 22'h000000;
            len          <= 22'h000000;
            tgt          <= 3'h0;
            sif.coil     <= 6'h00;
            sif.clr_line <= 1'b0;
            sif.busy     <= 1'b0;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            len          <= next_len;
            tgt          <= next_tgt;
            sif.coil     <= next_coil;
            sif.clr_line <= next_clr;
            sif.busy     <= next_busy;
        end
    end
endmodule : mrd_coil_seq

// ===== tb/mrd_switch_model.sv
`timescale 1ns/1ps
// latching switch bank; spare contacts follow the coil last driven
module mrd_switch_model (
    input  wire logic        ref_clk,
    input  wire logic [11:0] spdt_coil,
    input  wire logic [1:0]  sp6t_clear,
    input  wire logic [11:0] sp6t_coil,
    output logic      [11:0] spdt_position_readback,
    output logic      [11:0] sp6t_position_readback
);
    // no reset input: a latching throw survives power loss
    logic [5:0]  throw = 6'h00;
    logic [11:0] pos6  = 12'h000;
    // coil moves the contact; clear breaks the six-way switch
    always @(posedge ref_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (spdt_coil[2*i]) throw[i] <= 1'b0;
            if (spdt_coil[2*i+1]) throw[i] <= 1'b1;
        end
        for (int s = 0; s < 2; s++) begin
            if (sp6t_clear[s]) pos6[6*s+:6] <= 6'h00;
            else if (|sp6t_coil[6*s+:6]) pos6[6*s+:6] <= sp6t_coil[6*s+:6];
        end
    end
    // two spare contacts per two-way relay, one per six-way position; all report mechanical throw
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            spdt_position_readback[2*i]   = ~throw[i];
            spdt_position_readback[2*i+1] = throw[i];
        end
        sp6t_position_readback = pos6;
    end
endmodule : mrd_switch_model

// ===== tb/mrd_top_chk.sv
`timescale 1ns/1ps
module mrd_top_chk (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [31:0] relay_drive,
    input wire logic [11:0] spdt_coil,
    input wire logic [1:0]  sp6t_clear,
    input wire logic [11:0] sp6t_coil
);
    logic [21:0] dly, next_dly, hi_cnt, next_hi, clr_cnt, next_clr;
    // shadow of pulse length; assumes one switch pulsing at a time
    always_comb begin
        next_dly = dly;
        if (reg_wr && reg_addr == mrd_pkg::DELAY_OFF) begin
            next_dly = (reg_wdata == 16'h0000) ? 22'h000001 : 22'(reg_wdata);
        end
        next_hi  = (|spdt_coil) ? hi_cnt + 22'h000001 : 22'h000000;
        next_clr = sp6t_clear[0] ? clr_cnt + 22'h000001 : 22'h000000;
    end
    // register the helper counts
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dly     <= 22'(mrd_pkg::DELAY_RESET);
            hi_cnt  <= 22'h000000;
            clr_cnt <= 22'h000000;
        end else begin
            dly     <= next_dly;
            hi_cnt  <= next_hi;
            clr_cnt <= next_clr;
        end
    end
    a_coil_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(|spdt_coil) |-> hi_cnt == 22'(dly * mrd_pkg::UNIT_CYCLES)) else $error("coil pulse length wrong");
    a_clear_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(sp6t_clear[0]) |-> clr_cnt == 22'(dly * mrd_pkg::UNIT_CYCLES)) else $error("clear pulse length wrong");
    a_set_follows_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(sp6t_clear[0]) |-> |sp6t_coil[5:0]) else $error("no set right after clear");
    a_clear_before_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(|sp6t_coil[5:0]) |-> $past(sp6t_clear[0])) else $error("set without prior clear");
    a_clear_has_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(sp6t_clear[0]) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == mrd_pkg::SP6T_CMD_OFF)
        else $error("clear pulse without command");
    a_coil_has_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(|spdt_coil) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == mrd_pkg::SPDT_CMD_OFF)
        else $error("coil pulse without command");
    a_relay_low_word: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(reg_wr) && $past(reg_addr) == mrd_pkg::RELAY_LOW_OFF |-> relay_drive[15:0] == $past(reg_wdata))
        else $error("low relay word not applied");
    a_relay_high_word: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(reg_wr) && $past(reg_addr) == mrd_pkg::RELAY_HIGH_OFF |-> relay_drive[31:16] == $past(reg_wdata))
        else $error("high relay word not applied");
    a_relay_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !$past(reg_wr) |-> $stable(relay_drive)) else $error("relay drive changed without write");
endmodule : mrd_top_chk

bind mrd_top mrd_top_chk i_chk (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .relay_drive,
    .spdt_coil, .sp6t_clear, .sp6t_coil);

// ===== tb/mrd_top_tb.sv
`timescale 1ns/1ps
module mrd_top_tb;
    logic        ref_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic [11:0] reg_addr  = 12'h000;
    logic        reg_wr    = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [31:0] relay_drive;
    logic [11:0] spdt_coil, sp6t_coil, spdt_position_readback, sp6t_position_readback, exp2, exp6;
    logic [1:0]  sp6t_clear;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    // 40 MHz reference
    initial forever #12.5 ref_clk = ~ref_clk;
    mrd_top i_dut (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .relay_drive,
        .spdt_coil, .sp6t_clear, .sp6t_coil, .spdt_position_readback, .sp6t_position_readback);
    mrd_switch_model i_sw (.ref_clk, .spdt_coil, .sp6t_clear, .sp6t_coil,
        .spdt_position_readback, .sp6t_position_readback);
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one-cycle strobe; returns once the write edge has landed
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string name);
        @(posedge ref_clk);
        reg_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(name, {16'h0000, exp}, {16'h0000, reg_rdata});
    endtask : rd
    // poll busy, bounded; a dropped command never shows busy and times out
    task automatic wait_idle;
        bit seen;
        seen = 1'b0;
        for (int k = 0; k < 400; k++) begin
            @(posedge ref_clk);
            reg_addr <= mrd_pkg::BUSY_OFF;
            #1;
            if (reg_rdata[7:0] !== 8'h00) seen = 1'b1;
            else if (seen) return;
        end
        n_mismatch++;
        $display("[ERR] busy expected pulse then 00 seen none or stuck");
        give_verdict;
    endtask : wait_idle
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(mrd_pkg::RELAY_LOW_OFF, mrd_pkg::RELAY_RESET, "relay_low");
        rd(mrd_pkg::DELAY_OFF, mrd_pkg::DELAY_RESET, "delay");
        wr(mrd_pkg::RELAY_LOW_OFF, 16'h8001);
        chk("relay_drive", 32'h00008001, relay_drive);
        wr(mrd_pkg::RELAY_HIGH_OFF, 16'h8001);
        chk("relay_drive", 32'h80018001, relay_drive);
        wr(12'h404, 16'hffff);
        rd(12'h404, 16'h0000, "unmapped");
        rd(mrd_pkg::RELAY_HIGH_OFF, 16'h8001, "relay_high");
        wr(mrd_pkg::DELAY_OFF, 16'h0001);
        exp2 = 12'h555;
        rd(mrd_pkg::SPDT_RB_OFF, {4'h0, exp2}, "spdt_rb");
        // every two-way switch to both throws
        for (int i = 0; i < 6; i++) begin
            for (int p = 0; p < 2; p++) begin
                wr(mrd_pkg::SPDT_CMD_OFF, 16'(p * 8 + i));
                wait_idle;
                exp2[2*i]   = (p == 0);
                exp2[2*i+1] = (p == 1);
                rd(mrd_pkg::SPDT_RB_OFF, {4'h0, exp2}, "spdt_rb");
            end
        end
        // six-way switches; repeating a channel must break and re-make
        wr(mrd_pkg::CONFIG_OFF, 16'h0003);
        exp6 = 12'h000;
        for (int s = 0; s < 2; s++) begin
            for (int j = 0; j < 3; j++) begin
                wr(mrd_pkg::SP6T_CMD_OFF, 16'(((j == 2) ? 5 : 2) * 2 + s));
                wait_idle;
                exp6[6*s+:6] = 6'h01 << ((j == 2) ? 5 : 2);
                rd(mrd_pkg::SP6T_RB_OFF, {4'h0, exp6}, "sp6t_rb");
            end
        end
        // unfitted slot and out-of-range channel leave positions alone
        wr(mrd_pkg::CONFIG_OFF, 16'h0001);
        rd(mrd_pkg::CONFIG_OFF, 16'h0001, "config");
        wr(mrd_pkg::SP6T_CMD_OFF, 16'h0001);
        wr(mrd_pkg::SP6T_CMD_OFF, 16'h000c);
        repeat (60) @(posedge ref_clk);
        rd(mrd_pkg::SP6T_RB_OFF, {4'h0, exp6}, "sp6t_rb");
        // reset mid-run: no pulse follows, read-back still live
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("pulses", 32'h0, {6'h00, sp6t_clear, spdt_coil, sp6t_coil});
        chk("relay_drive", 32'h0, relay_drive);
        rd(mrd_pkg::SP6T_RB_OFF, {4'h0, exp6}, "sp6t_rb");
        rd(mrd_pkg::SPDT_RB_OFF, {4'h0, exp2}, "spdt_rb");
        // power back: program a pulse length, then re-establish a switch
        wr(mrd_pkg::DELAY_OFF, 16'h0001);
        wr(mrd_pkg::SPDT_CMD_OFF, 16'h0000);
        wait_idle;
        exp2[1:0] = 2'b01;
        rd(mrd_pkg::SPDT_RB_OFF, {4'h0, exp2}, "spdt_rb");
        give_verdict;
    end
endmodule : mrd_top_tb
